/* design/asim_pkg.sv */
// Notes on behaviour
// RULE1: threshold flag set when magnitude exceeds level
// RULE2: with counter, flag waits for count match
// RULE3: threshold flag valid only with comparator enabled
// RULE4: overrange flag set on gross overrange when enabled
// RULE5: overrange re-evaluated every 125 us
// RULE6: overrange sticky; cleared by disable or gain change
// RULE7: aux ready set on stored result or calibration
// RULE8: aux ready clears after aux then primary read
// RULE9: primary read needed even if primary disabled
// RULE10: primary ready set on stored result or calibration
// RULE11: primary data read clears primary ready
// RULE12: mask bits mirror low status byte, one enables
// RULE13: mask resets to zero
// RULE14: mask bit 6 gates accumulator threshold flag
// RULE15: mask bits 4,3,1,0 gate their flags
// RULE16: software ignores reserved bits 2, 5, 7
// RULE17: data register held until ready flag cleared; a new result overwrites it while core_pd_in is high
// RULE18: software reads status on interrupt
// RULE19: interrupt is or of flag and mask pairs
package asim_pkg;
  localparam int          DATA_W       = 24;
  localparam int          ADDR_W       = 32;
  localparam int          WORD_W       = 32;
  localparam logic [31:0] STATUS_ADDR  = 32'hFFFF0500;
  localparam logic [31:0] MASK_ADDR    = 32'hFFFF0504;
  localparam logic [31:0] CFG_ADDR     = 32'hFFFF050C;
  localparam logic [31:0] PCTL_ADDR    = 32'hFFFF0510;
  localparam logic [31:0] PDAT_ADDR    = 32'hFFFF0514;
  localparam logic [31:0] ADAT_ADDR    = 32'hFFFF0518;
  localparam logic [31:0] PTH_ADDR     = 32'hFFFF051C;
  localparam logic [31:0] TCL_ADDR     = 32'hFFFF0520;
  localparam int          BIT_PRDY     = 0;
  localparam int          BIT_ARDY     = 1;
  localparam int          BIT_POVR     = 3;
  localparam int          BIT_PTH      = 4;
  localparam int          BIT_ATH      = 6;
  localparam logic [7:0]  FLAG_USED    = 8'h5B;
  localparam logic [7:0]  MASK_RST     = 8'h00;
  localparam int          CFG_OVR_EN   = 2;
  localparam int          CFG_CMP_EN   = 3;
  localparam int          CFG_CNT_EN   = 4;
  localparam int          PCTL_GAIN_LO = 0;
  localparam int          PCTL_GAIN_HI = 3;
  localparam int          CLK_MHZ      = 100;
  localparam int          OVR_US       = 125;
  localparam int          OVR_CYC      = OVR_US * CLK_MHZ;
  localparam int          OVR_CNT_W    = 14;
  typedef enum logic [2:0] {
    ASIM_IDLE = 3'b001,
    ASIM_RD   = 3'b010,
    ASIM_WR   = 3'b100
  } asim_bus_t;
endpackage

/* design/asim_if.sv */
`timescale 1ns/10ps
interface asim_if;
  logic        req;
  logic        wr;
  logic [31:0] addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic        ack;
  logic        irq;
  modport dev  (input req, wr, addr, wdata, output rdata, ack, irq);
  modport host (output req, wr, addr, wdata, input rdata, ack, irq);
endinterface

/* design/asim_ovr_tick.sv */
`timescale 1ns/10ps
module asim_ovr_tick
  import asim_pkg::*;
(
  // clock and reset
  input  wire logic sys_clk_in,
  input  wire logic rst_in,
  // tick
  output logic      tick_out
);
  import asim_pkg::*;
  logic [OVR_CNT_W-1:0] cnt_ff;
  always_ff @(posedge sys_clk_in) begin
    if (rst_in || cnt_ff == OVR_CNT_W'(OVR_CYC - 1)) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= cnt_ff + 1'b1;
    end
  end
  assign tick_out = (cnt_ff == OVR_CNT_W'(OVR_CYC - 1)); // RULE5
endmodule

/* design/asim_device.sv */
`timescale 1ns/10ps
module asim_device
  import asim_pkg::*;
(
  // clock and reset
  input  wire logic              sys_clk_in,
  input  wire logic              rst_in,
  // register port
  asim_if.dev                    bus,
  // conversion engines
  input  wire logic              prim_en_in,
  input  wire logic              aux_en_in,
  input  wire logic              prim_valid_in,
  input  wire logic [DATA_W-1:0] prim_data_in,
  input  wire logic              aux_valid_in,
  input  wire logic [DATA_W-1:0] aux_data_in,
  input  wire logic              cal_done_in,
  input  wire logic              gross_ovr_in,
  input  wire logic              accum_over_in,
  input  wire logic              core_pd_in
);
  import asim_pkg::*;
  logic [7:0]        irq_en_ff, cfg_ff, pctl_ff;
  logic [7:0]        flags, gated;
  logic              prim_rdy_ff, aux_rdy_ff, pth_ff, povr_ff, ath_ff;
  logic [DATA_W-1:0] prim_res_ff, aux_res_ff, prim_lvl_ff;
  logic [15:0]       tcl_ff, tcnt_ff;
  logic              aux_read_ff, ovr_tick;
  logic              rd, wr, rd_p, rd_a, wr_cfg, wr_pctl, ovr_clr;
  logic [DATA_W-1:0] mag;
  logic              exceed;
  logic [31:0]       nxt_rdata;

  asim_ovr_tick u_tick (
    .sys_clk_in (sys_clk_in),
    .rst_in     (rst_in),
    .tick_out   (ovr_tick)
  );

  // bus decode, only one request in flight at a time
  assign rd      = bus.req && !bus.wr;
  assign wr      = bus.req && bus.wr;
  assign rd_p    = rd && bus.addr == PDAT_ADDR;
  assign rd_a    = rd && bus.addr == ADAT_ADDR;
  assign wr_cfg  = wr && bus.addr == CFG_ADDR;
  assign wr_pctl = wr && bus.addr == PCTL_ADDR;
  assign mag     = prim_data_in[DATA_W-1] ? DATA_W'(-prim_data_in) : prim_data_in;
  assign exceed  = mag > prim_lvl_ff; // RULE1
  // gain change is judged against the stored gain, not the other fields
  assign ovr_clr = (wr_cfg && !bus.wdata[CFG_OVR_EN]) ||
                   (wr_pctl && bus.wdata[PCTL_GAIN_HI:PCTL_GAIN_LO] != pctl_ff[PCTL_GAIN_HI:PCTL_GAIN_LO]);

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      irq_en_ff   <= MASK_RST; // RULE13
      cfg_ff      <= '0;
      pctl_ff     <= '0;
      prim_lvl_ff <= '0;
      tcl_ff      <= '0;
    end else if (wr) begin
      // reserved mask positions never hold a one
      case (bus.addr)
        MASK_ADDR: irq_en_ff   <= bus.wdata[7:0] & FLAG_USED; // RULE12
        CFG_ADDR:  cfg_ff      <= bus.wdata[7:0];
        PCTL_ADDR: pctl_ff     <= bus.wdata[7:0];
        PTH_ADDR:  prim_lvl_ff <= bus.wdata[DATA_W-1:0];
        TCL_ADDR:  tcl_ff      <= bus.wdata[15:0];
        default:   ;
      endcase
    end
  end

  // results held until ready cleared, except while core is down
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      prim_res_ff <= '0;
      aux_res_ff  <= '0;
    end else begin
      if (prim_en_in && prim_valid_in && (!prim_rdy_ff || core_pd_in)) begin
        prim_res_ff <= prim_data_in; // RULE17
      end
      if (aux_en_in && aux_valid_in && (!aux_rdy_ff || core_pd_in)) begin
        aux_res_ff <= aux_data_in; // RULE17
      end
    end
  end

  // threshold run counter
  always_ff @(posedge sys_clk_in) begin
    if (rst_in || !cfg_ff[CFG_CNT_EN]) begin
      tcnt_ff <= '0;
    end else if (prim_en_in && prim_valid_in) begin
      tcnt_ff <= exceed ? tcnt_ff + 1'b1 : '0;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      aux_read_ff <= 1'b0;
    end else if (rd_a) begin
      aux_read_ff <= 1'b1;
    end else if (rd_p) begin
      aux_read_ff <= 1'b0;
    end
  end

  // sets win over read clears, so a calibration in the read cycle is not lost
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      prim_rdy_ff <= 1'b0;
    end else if (prim_en_in && ((prim_valid_in && !prim_rdy_ff) || cal_done_in)) begin
      prim_rdy_ff <= 1'b1; // RULE10
    end else if (rd_p) begin
      prim_rdy_ff <= 1'b0; // RULE11
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      aux_rdy_ff <= 1'b0;
    end else if (aux_en_in && ((aux_valid_in && !aux_rdy_ff) || cal_done_in)) begin
      aux_rdy_ff <= 1'b1; // RULE7
    end else if (rd_p && aux_read_ff) begin
      aux_rdy_ff <= 1'b0; // RULE8 RULE9
    end
  end

  // comparator flag follows the latest result, forced clear while comparator is off
  always_ff @(posedge sys_clk_in) begin
    if (rst_in || !cfg_ff[CFG_CMP_EN]) begin
      pth_ff <= 1'b0; // RULE3
    end else if (prim_en_in && prim_valid_in) begin
      if (cfg_ff[CFG_CNT_EN]) begin
        pth_ff <= exceed && (tcnt_ff + 1'b1 == tcl_ff); // RULE2
      end else begin
        pth_ff <= exceed; // RULE1
      end
    end
  end

  // sticky; a tick landing on the clearing write keeps it set
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      povr_ff <= 1'b0;
    end else if (cfg_ff[CFG_OVR_EN] && ovr_tick && gross_ovr_in) begin
      povr_ff <= 1'b1; // RULE4 RULE5
    end else if (ovr_clr) begin
      povr_ff <= 1'b0; // RULE6
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      ath_ff <= 1'b0;
    end else begin
      ath_ff <= accum_over_in; // RULE14
    end
  end

  // reserved positions read as zero
  always_comb begin
    flags           = '0;
    flags[BIT_PRDY] = prim_rdy_ff;
    flags[BIT_ARDY] = aux_rdy_ff;
    flags[BIT_POVR] = povr_ff;
    flags[BIT_PTH]  = pth_ff;
    flags[BIT_ATH]  = ath_ff;
  end

  // unmapped addresses read as zero
  always_comb begin
    nxt_rdata = '0;
    case (bus.addr)
      STATUS_ADDR: nxt_rdata[7:0]        = flags;
      MASK_ADDR:   nxt_rdata[7:0]        = irq_en_ff;
      CFG_ADDR:    nxt_rdata[7:0]        = cfg_ff;
      PCTL_ADDR:   nxt_rdata[7:0]        = pctl_ff;
      PDAT_ADDR:   nxt_rdata[DATA_W-1:0] = prim_res_ff;
      ADAT_ADDR:   nxt_rdata[DATA_W-1:0] = aux_res_ff;
      PTH_ADDR:    nxt_rdata[DATA_W-1:0] = prim_lvl_ff;
      TCL_ADDR:    nxt_rdata[15:0]       = tcl_ff;
      default:     nxt_rdata             = '0;
    endcase
  end

  // ack one cycle after every request, read data with it
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      bus.rdata <= '0;
      bus.ack   <= 1'b0;
    end else begin
      bus.ack <= bus.req;
      if (rd) begin
        bus.rdata <= nxt_rdata;
      end
    end
  end

  // one gate per status position
  for (genvar i = 0; i < $bits(flags); i++) begin : g_gate
    assign gated[i] = flags[i] & irq_en_ff[i]; // RULE15
  end

  assign bus.irq = |gated; // RULE19
endmodule

/* design/asim_host.sv */
`timescale 1ns/10ps
module asim_host
  import asim_pkg::*;
(
  // clock and reset
  input  wire logic        sys_clk_in,
  input  wire logic        rst_in,
  // register port
  asim_if.host             bus,
  // user command
  input  wire logic        cmd_valid_in,
  input  wire logic        cmd_wr_in,
  input  wire logic [31:0] cmd_addr_in,
  input  wire logic [31:0] cmd_wdata_in,
  output logic             cmd_ready_out,
  output logic             rsp_valid_out,
  output logic [31:0]      rsp_data_out,
  output logic             irq_out
);
  import asim_pkg::*;
  asim_bus_t state_ff;
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      state_ff  <= ASIM_IDLE;
      bus.req   <= 1'b0;
      bus.wr    <= 1'b0;
      bus.addr  <= '0;
      bus.wdata <= '0;
    end else begin
      case (state_ff)
        ASIM_IDLE: begin
          if (cmd_valid_in) begin
            // RULE8 RULE9 software issues aux then primary read
            bus.req   <= 1'b1;
            bus.wr    <= cmd_wr_in;
            bus.addr  <= cmd_addr_in;
            bus.wdata <= cmd_wdata_in;
            state_ff  <= cmd_wr_in ? ASIM_WR : ASIM_RD;
          end
        end
        ASIM_RD, ASIM_WR: begin
          bus.req <= 1'b0;
          if (bus.ack) begin
            state_ff <= ASIM_IDLE;
          end
        end
        default: state_ff <= ASIM_IDLE;
      endcase
    end
  end
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      rsp_valid_out <= 1'b0;
      rsp_data_out  <= '0;
    end else begin
      rsp_valid_out <= bus.ack;
      if (bus.ack && state_ff == ASIM_RD) begin
        rsp_data_out <= bus.rdata & (bus.addr == STATUS_ADDR ? {24'h0, FLAG_USED} : 32'hFFFFFFFF); // RULE16
      end
    end
  end
  assign cmd_ready_out = (state_ff == ASIM_IDLE);
  assign irq_out       = bus.irq; // RULE18
endmodule

/* testbench/asim_monitor.sv */
`timescale 1ns/10ps
module asim_monitor
  import asim_pkg::*;
(
  // clock and reset
  input wire logic        sys_clk_in,
  input wire logic        rst_in,
  // register port
  input wire logic        req,
  input wire logic        wr,
  input wire logic [31:0] addr,
  input wire logic [31:0] wdata,
  input wire logic [31:0] rdata,
  input wire logic        ack,
  input wire logic        irq
);
  import asim_pkg::*;
  // shadow of the mask, reserved bits dropped
  logic [7:0] mask_ff;
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      mask_ff <= MASK_RST;
    end else if (req && wr && addr == MASK_ADDR) begin
      mask_ff <= wdata[7:0] & FLAG_USED;
    end
  end
  default clocking dc @(posedge sys_clk_in);
  endclocking
  default disable iff (rst_in);
  sequence s_read(logic [31:0] a);
    req && !wr && addr == a ##1 ack;
  endsequence
  a_ack_after_req: assert property (req |=> ack) else $error("no ack after request");
  a_ack_one_cycle: assert property (ack |=> !ack) else $error("ack held too long");
  a_ack_has_cause: assert property (ack |-> $past(req)) else $error("ack without request");
  a_mask_readback: assert property (s_read(MASK_ADDR) |-> rdata == {24'h000000, mask_ff})
    else $error("mask readback wrong");
  a_status_reserved: assert property (s_read(STATUS_ADDR) |-> !rdata[7] && !rdata[5] && !rdata[2])
    else $error("reserved status bit set");
  a_irq_masked_off: assert property (mask_ff == 8'h00 && $past(mask_ff) == 8'h00 |-> !irq)
    else $error("irq with all sources masked");
  // irq of the read cycle, when the returned status was captured
  a_irq_has_source: assert property ((s_read(STATUS_ADDR) ##0 $past(irq)) |-> (rdata[7:0] & mask_ff) != 8'h00)
    else $error("irq without enabled flag");
  a_irq_stays_quiet: assert property ((s_read(STATUS_ADDR) ##0 !$past(irq)) |-> (rdata[7:0] & mask_ff) == 8'h00)
    else $error("enabled flag without irq");
endmodule

/* testbench/asim_bench.sv */
`timescale 1ns/10ps
module asim_bench;
  import asim_pkg::*;
  logic        clk = 0, rst = 1, cv = 0, cw = 0, pe = 0, ae = 0;
  logic        pv = 0, av = 0, cd = 0, go = 0, ao = 0, pdn = 0;
  logic [31:0] ca = 0, cwd = 0, rd;
  logic [23:0] pd = 0, ad = 0;
  logic        cr, rv, irq;
  logic [31:0] rdo;
  int          err_count = 0, total_checks = 0, cyc = 0;
  asim_if bus_if();
  asim_device u_asim_device(.sys_clk_in(clk), .rst_in(rst), .bus(bus_if), .prim_en_in(pe), .aux_en_in(ae),
    .prim_valid_in(pv), .prim_data_in(pd), .aux_valid_in(av), .aux_data_in(ad), .cal_done_in(cd),
    .gross_ovr_in(go), .accum_over_in(ao), .core_pd_in(pdn));
  asim_host u_asim_host(.sys_clk_in(clk), .rst_in(rst), .bus(bus_if), .cmd_valid_in(cv), .cmd_wr_in(cw),
    .cmd_addr_in(ca), .cmd_wdata_in(cwd), .cmd_ready_out(cr), .rsp_valid_out(rv), .rsp_data_out(rdo), .irq_out(irq));
  asim_monitor u_asim_monitor(.sys_clk_in(clk), .rst_in(rst), .req(bus_if.req), .wr(bus_if.wr), .addr(bus_if.addr),
    .wdata(bus_if.wdata), .rdata(bus_if.rdata), .ack(bus_if.ack), .irq(bus_if.irq));
  initial begin
    forever begin
      #5;
      clk = ~clk;
    end
  end
  // overrange waits dominate the run
  always @(posedge clk) begin
    cyc++;
    if (cyc > 70000) begin
      err_count++;
      results();
    end
  end
  task automatic step(int n);
    repeat (n) begin
      @(posedge clk);
      #1;
    end
  endtask
  task automatic chk(logic [31:0] g, logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic xfer(logic w, logic [31:0] a, logic [31:0] d);
    int n;
    n = 0;
    while (cr !== 1'b1 && n < 20) begin
      step(1);
      n++;
    end
    cv = 1;
    cw = w;
    ca = a;
    cwd = d;
    step(1);
    cv = 0;
    n = 0;
    while (rv !== 1'b1 && n < 20) begin
      step(1);
      n++;
    end
    if (n == 20) begin
      err_count++;
    end
    rd = rdo;
    step(1);
  endtask
  task automatic rdc(logic [31:0] a, logic [31:0] m, logic [31:0] e);
    xfer(0, a, 0);
    chk(rd & m, e);
  endtask
  task automatic ev(logic p, logic [23:0] d);
    pd = d;
    ad = d;
    pv = p;
    av = !p;
    step(1);
    pv = 0;
    av = 0;
    step(1);
  endtask
  task results;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    step(2);
    rst = 0;
    rdc(MASK_ADDR, '1, 0);
    xfer(1, MASK_ADDR, 32'hFF);
    rdc(MASK_ADDR, '1, 32'h5B);
    rdc(32'hFFFF0540, '1, 0);
    pe = 1;
    ev(1, 24'h000123);
    ev(1, 24'h000456);
    rdc(STATUS_ADDR, 32'hFF, 32'h01);
    chk(irq, 1);
    rdc(PDAT_ADDR, 32'hFFFFFF, 32'h123);
    rdc(STATUS_ADDR, 32'hFF, 0);
    // core powered down: newest result replaces the unread one
    pdn = 1;
    ev(1, 24'h000321);
    ev(1, 24'h000654);
    pdn = 0;
    rdc(PDAT_ADDR, 32'hFFFFFF, 32'h654);
    rdc(STATUS_ADDR, 32'hFF, 0);
    ev(0, 24'h000999);
    rdc(STATUS_ADDR, 32'hFF, 0);
    pe = 0;
    ae = 1;
    ev(0, 24'h000777);
    xfer(0, PDAT_ADDR, 0);
    rdc(STATUS_ADDR, 32'hFF, 32'h02);
    rdc(ADAT_ADDR, 32'hFFFFFF, 32'h777);
    rdc(STATUS_ADDR, 32'hFF, 32'h02);
    xfer(0, PDAT_ADDR, 0);
    rdc(STATUS_ADDR, 32'hFF, 0);
    // calibration sets both ready flags with primary and aux enabled
    pe = 1;
    cd = 1;
    step(1);
    cd = 0;
    rdc(STATUS_ADDR, 32'hFF, 32'h03);
    xfer(0, ADAT_ADDR, 0);
    xfer(0, PDAT_ADDR, 0);
    rdc(STATUS_ADDR, 32'hFF, 0);
    xfer(1, PTH_ADDR, 32'h100);
    xfer(1, CFG_ADDR, 32'h08);
    ev(1, 24'hFFFE00);
    rdc(STATUS_ADDR, 32'hFF, 32'h11);
    chk(irq, 1);
    xfer(0, PDAT_ADDR, 0);
    ev(1, 24'h000050);
    rdc(STATUS_ADDR, 32'hFF, 32'h01);
    xfer(0, PDAT_ADDR, 0);
    xfer(1, TCL_ADDR, 32'h2);
    xfer(1, CFG_ADDR, 32'h18);
    ev(1, 24'h000200);
    rdc(STATUS_ADDR, 32'h10, 0);
    xfer(0, PDAT_ADDR, 0);
    ev(1, 24'h000300);
    rdc(STATUS_ADDR, 32'h10, 32'h10);
    xfer(0, PDAT_ADDR, 0);
    xfer(1, MASK_ADDR, 32'h40);
    ao = 1;
    step(1);
    rdc(STATUS_ADDR, 32'h40, 32'h40);
    chk(irq, 1);
    xfer(1, MASK_ADDR, 32'h00);
    chk(irq, 0);
    ao = 0;
    xfer(1, CFG_ADDR, 32'h04);
    rdc(STATUS_ADDR, 32'h50, 0);
    go = 1;
    step(12600);
    rdc(STATUS_ADDR, 32'h08, 32'h08);
    go = 0;
    step(12600);
    rdc(STATUS_ADDR, 32'h08, 32'h08);
    xfer(1, PCTL_ADDR, 32'h1);
    rdc(STATUS_ADDR, 32'h08, 0);
    go = 1;
    step(12600);
    rdc(STATUS_ADDR, 32'h08, 32'h08);
    // input quiet first so no tick can set the flag on the disabling write
    go = 0;
    xfer(1, CFG_ADDR, 32'h00);
    rdc(STATUS_ADDR, 32'h08, 0);
    xfer(1, MASK_ADDR, 32'h1B);
    rst = 1;
    step(2);
    rst = 0;
    rdc(MASK_ADDR, '1, 0);
    chk(irq, 0);
    results();
  end
endmodule
